//--- verilog/irq_ctrl_pkg.sv
// Package of constants and types for the four-source interrupt control block
// Summary of operation
// - Main reg bits 0-3: master, ext, timer, timebase enables
// - Main reg flags bits 4-6; bit 7 reads zero
// - Second reg: rtc enable bit0, flag bit4
// - Registers at data addresses 0x0b and 0x1e
// - Timebase request calls 0x0c, clears flag, master
// - Rtc request calls 0x10, clears flag, master
// - No nesting until return or re-enable
// - Return-from-interrupt sets master; plain return does not
// - Requests evaluated at next second-phase strobe
// - Fixed priority: ext, timer, timebase, rtc
// - Master enable zero blocks all service
// - Disabled source never serviced, flag still recorded
// - Flags stay set until acknowledged or cleared
// - Falling pin edge sets ext flag; vector 0x04
// - Timer overflow sets timer flag; vector 0x08
// - Full stack blocks every acknowledge
// - Acknowledge pushes only the program counter
package irq_ctrl_pkg;
  localparam logic [7:0] main_reg_addr = 8'h0b;
  localparam logic [7:0] rtc_reg_addr = 8'h1e;
  localparam int master_bit = 0;
  localparam int ext_en_bit = 1;
  localparam int timer_en_bit = 2;
  localparam int timebase_en_bit = 3;
  localparam int ext_flag_bit = 4;
  localparam int timer_flag_bit = 5;
  localparam int timebase_flag_bit = 6;
  localparam int rtc_en_bit = 0;
  localparam int rtc_flag_bit = 4;
  localparam logic [7:0] ext_vector = 8'h04;
  localparam logic [7:0] timer_vector = 8'h08;
  localparam logic [7:0] timebase_vector = 8'h0c;
  localparam logic [7:0] rtc_vector = 8'h10;
  localparam logic [3:0] enable_reset = 4'h0;
  localparam logic [3:0] flag_reset = 4'h0;
  localparam int sync_stages = 3;

  // Source order in every 4-bit vector: 0 ext, 1 timer, 2 timebase, 3 rtc
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic strobe;
    logic stack_full;
    logic return_from_interrupt;
  } core_ctl_t;

  typedef struct packed {
    logic valid;
    logic [7:0] vector;
  } ack_t;
endpackage : irq_ctrl_pkg

//--- verilog/pin_edge_sync.sv
// Three-stage pin synchroniser with falling edge detect
module pin_edge_sync (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic pin,
  output logic fall
);
  import irq_ctrl_pkg::*;

  logic [sync_stages-1:0] stage;
  logic settled;

  // Idle high so reset does not fake an edge; stage 0 only feeds stage 1
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      stage <= '1;
    end else begin
      stage <= {stage[sync_stages-2:0], pin};
    end
  end

  // Level moves only when stages two and three agree, so a one-cycle glitch never counts
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      settled <= 1'b1;
    end else if (stage[1] == stage[2]) begin
      settled <= stage[2];
    end
  end

  // Falling edge: settled level high while both late stages now agree low
  assign fall = settled & ~stage[1] & ~stage[2];
endmodule : pin_edge_sync

//--- verilog/four_source_interrupt_control.sv
// Four-source interrupt controller: registers, flags, priority and acknowledge
module four_source_interrupt_control (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire irq_ctrl_pkg::reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  input wire irq_ctrl_pkg::core_ctl_t core_ctl,
  input wire logic ext_irq_pin_b,
  input wire logic timer_overflow,
  input wire logic timebase_tick,
  input wire logic rtc_tick,
  output irq_ctrl_pkg::ack_t ack,
  output logic push_pc
);
  import irq_ctrl_pkg::*;

  logic master_irq_enable;
  logic [3:0] src_enable;
  logic [3:0] flag;
  logic ext_request_flag;
  logic timer_request_flag;
  logic timebase_request_flag;
  logic rtc_request_flag;
  logic [3:0] event_in;
  logic ext_fall;
  logic [1:0] sel;
  logic wr_main;
  logic wr_rtc;
  logic rd_main;
  logic rd_rtc;
  logic [7:0] main_view;
  logic [7:0] rtc_view;
  logic [3:0] live;
  logic [3:0] grant;
  logic [3:0] clr_ack;
  logic take;

  // Fixed priority pick, lowest index wins
  function automatic logic [3:0] pick_first(input logic [3:0] req);
    logic [3:0] g;
    g = 4'h0;
    for (int i = 3; i >= 0; i--) begin
      if (req[i]) begin
        g = 4'h0;
        g[i] = 1'b1;
      end
    end
    return g;
  endfunction : pick_first

  // Vector for a one-hot grant
  function automatic logic [7:0] vector_of(input logic [3:0] g);
    case (g)
      4'b0001: return ext_vector;
      4'b0010: return timer_vector;
      4'b0100: return timebase_vector;
      4'b1000: return rtc_vector;
      default: return 8'h00;
    endcase
  endfunction : vector_of

  // Register select for a data address; bit 0 main, bit 1 rtc, nothing elsewhere
  function automatic logic [1:0] reg_sel(input logic [7:0] a);
    logic [1:0] s;
    s = 2'h0;
    if (a == main_reg_addr) begin
      s[0] = 1'b1;
    end
    if (a == rtc_reg_addr) begin
      s[1] = 1'b1;
    end
    return s;
  endfunction : reg_sel

  pin_edge_sync u_ext_sync (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .pin(ext_irq_pin_b),
    .fall(ext_fall)
  );

  // Address decode; one select feeds both the write and the read side
  assign sel = reg_sel(reg_req.addr);
  assign wr_main = reg_req.wr && sel[0];
  assign wr_rtc = reg_req.wr && sel[1];
  assign rd_main = reg_req.rd && sel[0];
  assign rd_rtc = reg_req.rd && sel[1];

  // Hardware events; pin edge, overflow and ticks are same-clock pulses
  assign event_in = {rtc_tick, timebase_tick, timer_overflow, ext_fall};

  // Sticky flags gathered in source order for the priority pick
  assign flag = {rtc_request_flag, timebase_request_flag, timer_request_flag, ext_request_flag};
  assign live = flag & src_enable;

  // Acknowledge only on the strobe, master on, stack room; flags latched between strobes
  assign take = core_ctl.strobe && master_irq_enable
    && !core_ctl.stack_full;
  assign grant = take ? pick_first(live) : 4'h0;
  assign clr_ack = grant;

  // Read images; bit 7 of main and the gaps of the rtc register are wired to zero
  assign main_view = {1'b0, flag[2:0], src_enable[2:0], master_irq_enable};
  assign rtc_view = {3'h0, flag[3], 3'h0, src_enable[3]};

  // Master enable: ack clears it, return-from-interrupt sets it, write is software's
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      master_irq_enable <= 1'b0;
    end else if (|grant) begin
      master_irq_enable <= 1'b0;
    end else if (core_ctl.return_from_interrupt) begin
      master_irq_enable <= 1'b1;
    end else if (wr_main) begin
      master_irq_enable <= reg_req.wdata[master_bit];
    end
  end

  // Source enables, written by software only
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      src_enable <= enable_reset;
    end else begin
      if (wr_main) begin
        src_enable[0] <= reg_req.wdata[ext_en_bit];
        src_enable[1] <= reg_req.wdata[timer_en_bit];
        src_enable[2] <= reg_req.wdata[timebase_en_bit];
      end
      if (wr_rtc) begin
        src_enable[3] <= reg_req.wdata[rtc_en_bit];
      end
    end
  end

  // External flag; a pin edge beats an ack or a software clear in the same cycle
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ext_request_flag <= flag_reset[0];
    end else if (event_in[0]) begin
      ext_request_flag <= 1'b1;
    end else if (clr_ack[0]) begin
      ext_request_flag <= 1'b0;
    end else if (wr_main) begin
      ext_request_flag <= reg_req.wdata[ext_flag_bit];
    end
  end

  // Timer flag; recorded even while the source is disabled
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      timer_request_flag <= flag_reset[1];
    end else if (event_in[1]) begin
      timer_request_flag <= 1'b1;
    end else if (clr_ack[1]) begin
      timer_request_flag <= 1'b0;
    end else if (wr_main) begin
      timer_request_flag <= reg_req.wdata[timer_flag_bit];
    end
  end

  // Time base flag; a tick that meets its own ack survives, so that tick is not lost
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      timebase_request_flag <= flag_reset[2];
    end else if (event_in[2]) begin
      timebase_request_flag <= 1'b1;
    end else if (clr_ack[2]) begin
      timebase_request_flag <= 1'b0;
    end else if (wr_main) begin
      timebase_request_flag <= reg_req.wdata[timebase_flag_bit];
    end
  end

  // Real time clock flag lives in the second register
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rtc_request_flag <= flag_reset[3];
    end else if (event_in[3]) begin
      rtc_request_flag <= 1'b1;
    end else if (clr_ack[3]) begin
      rtc_request_flag <= 1'b0;
    end else if (wr_rtc) begin
      rtc_request_flag <= reg_req.wdata[rtc_flag_bit];
    end
  end

  // Acknowledge registered: one-cycle pulse with vector; only the PC is pushed
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ack <= '0;
      push_pc <= 1'b0;
    end else begin
      ack.valid <= |grant;
      ack.vector <= (|grant) ? vector_of(grant) : 8'h00;
      push_pc <= |grant;
    end
  end

  // Read data, registered; other addresses and idle cycles read zero
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else if (rd_main) begin
      reg_rdata <= main_view;
    end else if (rd_rtc) begin
      reg_rdata <= rtc_view;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // Checks: acknowledge gating and timing
  ack_on_strobe_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    ack.valid |-> $past(core_ctl.strobe) && !$past(core_ctl.stack_full))
    else $error("ack without strobe or with full stack");
  no_strobe_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !core_ctl.strobe |-> grant == 4'h0)
    else $error("grant outside the strobe cycle");
  strobe_gate_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    take && live != 4'h0 |=> ack.valid)
    else $error("enabled request not served at the strobe");
  master_cleared_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    ack.valid |-> !master_irq_enable)
    else $error("master enable still set after ack");
  master_gate_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !master_irq_enable ##1 1 |-> !ack.valid)
    else $error("ack while master disabled");
  stack_full_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    core_ctl.stack_full |=> !ack.valid)
    else $error("ack while stack full");
  full_blocks_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    core_ctl.stack_full |-> grant == 4'h0)
    else $error("grant while stack full");
  single_ack_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    ack.valid |=> !ack.valid)
    else $error("nested ack without re-enable");
  master_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !master_irq_enable && !core_ctl.return_from_interrupt && !wr_main |=> !master_irq_enable)
    else $error("master enable came back on its own");
  return_from_interrupt_sets_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    core_ctl.return_from_interrupt && !take |=> master_irq_enable)
    else $error("return did not restore master enable");
  push_pair_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    push_pc == ack.valid)
    else $error("push and ack disagree");
  vector_idle_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !ack.valid |-> ack.vector == 8'h00)
    else $error("vector shown without ack");

  // Checks: priority and enables
  ext_priority_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    take && flag[0] && src_enable[0] |=> ack.vector == ext_vector)
    else $error("external not chosen first");
  timer_before_tb_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    take && live[1] && !live[0] |=> ack.vector == timer_vector)
    else $error("timer not chosen over lower sources");
  grant_onehot_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $onehot0(grant))
    else $error("more than one source granted");
  rtc_vector_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    take && (flag & src_enable) == 4'b1000 |=> ack.valid && ack.vector == rtc_vector)
    else $error("rtc vector wrong");
  disabled_src_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !src_enable[2] |=> ack.vector != timebase_vector)
    else $error("disabled time base serviced");

  // Checks: flag set and clear
  ext_edge_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    ext_fall |=> flag[0])
    else $error("pin edge not recorded");
  timer_event_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    timer_overflow |=> flag[1])
    else $error("timer overflow not recorded");
  timebase_event_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    timebase_tick |=> flag[2])
    else $error("time base tick not recorded");
  rtc_event_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    rtc_tick |=> flag[3])
    else $error("rtc tick not recorded");
  ext_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    grant[0] && !ext_fall |=> !flag[0] && ack.vector == ext_vector)
    else $error("external ack did not clear its flag");
  timer_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    grant[1] && !timer_overflow |=> !flag[1] && ack.vector == timer_vector)
    else $error("timer ack did not clear its flag");
  timebase_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    grant[2] && !timebase_tick |=> !flag[2] && ack.vector == timebase_vector)
    else $error("time base ack did not clear its flag");
  rtc_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    grant[3] && !rtc_tick |=> !flag[3] && !master_irq_enable)
    else $error("rtc ack did not clear flag and master");
  flag_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    flag[1] && !clr_ack[1] && !wr_main |=> flag[1])
    else $error("timer flag dropped");
  rtc_flag_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    flag[3] && !clr_ack[3] && !wr_rtc |=> flag[3])
    else $error("rtc flag dropped");

  // Checks: register map
  main_read_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    rd_main |=> reg_rdata[3:0] == $past({src_enable[2:0], master_irq_enable}))
    else $error("main register enables read back wrong");
  main_flags_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    rd_main |=> reg_rdata[7:4] == {1'b0, $past(flag[2:0])})
    else $error("main register flags read back wrong");
  rtc_read_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    rd_rtc |=> reg_rdata == {3'h0, $past(flag[3]), 3'h0, $past(src_enable[3])})
    else $error("rtc register read back wrong");
  unmapped_read_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    reg_req.rd && reg_sel(reg_req.addr) == 2'h0 |=> reg_rdata == 8'h00)
    else $error("unmapped address read nonzero");
  master_write_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    wr_main && !core_ctl.return_from_interrupt && grant == 4'h0 |=>
      master_irq_enable == $past(reg_req.wdata[master_bit]))
    else $error("master enable write lost");
  rtc_enable_write_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    wr_rtc |=> src_enable[3] == $past(reg_req.wdata[rtc_en_bit]))
    else $error("rtc enable write lost");

  // Main scenarios
  ext_ack_c: cover property (@(posedge ref_clk) ack.valid && ack.vector == ext_vector);
  timer_ack_c: cover property (@(posedge ref_clk) ack.valid && ack.vector == timer_vector);
  rtc_ack_c: cover property (@(posedge ref_clk) ack.valid && ack.vector == rtc_vector);
  tie_c: cover property (@(posedge ref_clk) take && $countones(flag & src_enable) > 1);
  return_from_interrupt_c: cover property (@(posedge ref_clk) ack.valid ##[1:20] core_ctl.return_from_interrupt);
endmodule : four_source_interrupt_control

//--- test/core_model.sv
// CPU sequencer stand-in: second-phase strobe, stack-full level, return pulse
module core_model (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic full,
  input wire logic ret_go,
  output irq_ctrl_pkg::core_ctl_t core_ctl
);
  timeunit 1ns;
  timeprecision 100ps;
  import irq_ctrl_pkg::*;
  logic [1:0] phase;

  // One strobe per four-clock machine cycle; all outputs registered like the real core
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      phase <= 2'h0;
      core_ctl <= '0;
    end else begin
      phase <= phase + 2'h1;
      core_ctl.strobe <= (phase == 2'h3);
      core_ctl.stack_full <= full;
      core_ctl.return_from_interrupt <= ret_go;
    end
  end
endmodule : core_model

//--- test/tb.sv
// Self-checking bench for the four-source interrupt controller
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import irq_ctrl_pkg::*;
  logic ref_clk = 0, rst_b = 0, full = 0, ret_go = 0, pin_b = 1;
  logic tmr = 0, tb_tick = 0, rtc = 0, push_pc, rd_seen = 0;
  reg_req_t req = '0;
  core_ctl_t ctl;
  ack_t ack;
  logic [7:0] rdata;
  logic [7:0] exp_q[$];
  logic [7:0] vec [4] = '{ext_vector, timer_vector, timebase_vector, rtc_vector};
  int fails = 0, cmp_count = 0;

  core_model partner (.ref_clk(ref_clk), .rst_b(rst_b), .full(full), .ret_go(ret_go),
    .core_ctl(ctl));
  four_source_interrupt_control dut (.ref_clk(ref_clk), .rst_b(rst_b), .reg_req(req),
    .reg_rdata(rdata), .core_ctl(ctl), .ext_irq_pin_b(pin_b), .timer_overflow(tmr),
    .timebase_tick(tb_tick), .rtc_tick(rtc), .ack(ack), .push_pc(push_pc));

  initial forever #2 ref_clk = ~ref_clk;

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : report_and_stop

  // An unexpected result meets an unknown note, so it always counts as a mismatch
  task automatic chk(input logic [7:0] got);
    logic [7:0] e;
    cmp_count++;
    e = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx;
    if (got !== e) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, e);
    end
  endtask : chk

  // Result watcher: acknowledges and read data both consume the oldest note
  always @(posedge ref_clk) begin
    if (ack.valid === 1'b1) chk(ack.vector);
    if (rd_seen) chk(rdata);
    if (push_pc !== ack.valid) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, push_pc, ack.valid);
    end
    rd_seen <= req.rd;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc

  // Strobes drop for a full cycle so back-to-back calls never assign twice at once
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req.addr = a;
    req.wdata = d;
    req.wr = 1;
    cyc(1);
    req.wr = 0;
    cyc(1);
  endtask : wr

  task automatic drain();
    int n;
    n = 0;
    while (exp_q.size() > 0 && n < 60) begin
      cyc(1);
      n++;
    end
    if (exp_q.size() > 0) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, 8'h00, exp_q.pop_front());
    end
  endtask : drain

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    req.addr = a;
    req.rd = 1;
    cyc(1);
    req.rd = 0;
    drain();
  endtask : rd

  // Pin held low long enough to clear the synchroniser
  task automatic fire(input int s);
    case (s)
      0: pin_b = 0;
      1: tmr = 1;
      2: tb_tick = 1;
      default: rtc = 1;
    endcase
    cyc(1);
    tmr = 0;
    tb_tick = 0;
    rtc = 0;
    cyc(4);
    pin_b = 1;
  endtask : fire

  task automatic retn();
    ret_go = 1;
    cyc(1);
    ret_go = 0;
    cyc(1);
  endtask : retn

  initial begin
    #20000;
    fails++;
    report_and_stop();
  end

  initial begin
    int s;
    s = $urandom(97260);
    repeat (4) @(posedge ref_clk);
    #1 rst_b = 1;
    cyc(1);
    rd(main_reg_addr, 8'h00);
    rd(rtc_reg_addr, 8'h00);
    rd(8'h05, 8'h00);
    wr(main_reg_addr, 8'hfe);
    wr(rtc_reg_addr, 8'hff);
    cyc(20);
    rd(main_reg_addr, 8'h7e);
    rd(rtc_reg_addr, 8'h11);
    exp_q.push_back(ext_vector);
    wr(main_reg_addr, 8'h7f);
    drain();
    cyc(20);
    rd(main_reg_addr, 8'h6e);
    for (int i = 1; i < 4; i++) begin
      exp_q.push_back(vec[i]);
      retn();
      drain();
    end
    retn();
    wr(main_reg_addr, 8'h01);
    fire(1);
    cyc(20);
    rd(main_reg_addr, 8'h21);
    full = 1;
    wr(main_reg_addr, 8'h25);
    cyc(20);
    exp_q.push_back(timer_vector);
    full = 0;
    drain();
    retn();
    wr(main_reg_addr, 8'h0f);
    for (int i = 0; i < 10; i++) begin
      s = $urandom_range(3);
      exp_q.push_back(vec[s]);
      fire(s);
      drain();
      retn();
    end
    report_and_stop();
  end
endmodule : tb
